/* File: fpmc_pkg.sv */
// Package for the front panel mode controller: constants, types, glyph codes.
// Assumes a 200 MHz clock and debounced, already-synchronous-free key pins.
`default_nettype none
package fpmc_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned LOCK_HOLD_S = 5;
    localparam int unsigned LOCK_HOLD_CYC = LOCK_HOLD_S * CLK_MHZ * 1000000;
    localparam int unsigned BLINK_MS = 250;
    localparam int unsigned BLINK_CYC = BLINK_MS * CLK_MHZ * 1000;
    localparam logic [2:0] BLINK_PHASES = 3'h6;
    // ==========================================================
    // Data limits and reset values (accel/decel in ms)
    localparam logic [15:0] SPEED_MAX = 16'h0fa0;
    localparam logic [15:0] SPEED_RST = 16'h0000;
    localparam logic [7:0] TORQUE_MAX = 8'h0fa;
    localparam logic [7:0] TORQUE_RST = 8'h0fa;
    localparam logic [15:0] ACC_FINE_MAX = 16'h03e7;
    localparam logic [15:0] ACC_COARSE_MIN = 16'h03e8;
    localparam logic [15:0] ACC_COARSE_MAX = 16'h7530;
    localparam logic [15:0] ACC_COARSE_STEP = 16'h000a;
    localparam logic [15:0] ACC_RST = 16'h0064;
    localparam int unsigned MON_SCREENS = 5;
    // ==========================================================
    // Display glyph selector
    typedef enum logic [3:0] {
        GL_VALUE = 4'h0, GL_LOCK_ON = 4'h1, GL_LOCK_OFF = 4'h2,
        GL_REMOTE_BUSY = 4'h3, GL_LOCAL_AGAIN = 4'h4, GL_ERROR = 4'h5,
        GL_ALARM = 4'h6, GL_WARNING = 4'h7, GL_IO = 4'h8, GL_BLANK = 4'h9
    } fpmc_glyph_t;
    typedef enum logic [1:0] {
        MODE_MONITOR = 2'h0, MODE_DATA = 2'h1, MODE_PARAM = 2'h2, MODE_TEST = 2'h3
    } fpmc_mode_t;
    // Monitor screens: speed, load, opnum, alarm, warning, io (index)
    typedef struct packed {
        logic mode;
        logic set;
        logic up;
        logic down;
    } fpmc_keys_t;
    typedef struct packed {
        logic [15:0] speed;
        logic [7:0] torque;
        logic [15:0] accel;
        logic [15:0] decel;
    } fpmc_data_t;
endpackage
`default_nettype wire

/* File: fpmc_top.sv */
// Front panel mode controller: key navigation, edit lock, tool lockout, test gating.
// Assumes keys and status inputs other than the alarm/warning codes are raw pins, synchronised here; one 200 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module fpmc_top #(
    parameter int unsigned LOCK_HOLD = fpmc_pkg::LOCK_HOLD_CYC,
    parameter int unsigned BLINK_LEN = fpmc_pkg::BLINK_CYC
) (
    // Clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    // Panel keys (raw pins)
    input wire fpmc_pkg::fpmc_keys_t KEYS_IN,
    // Edit command from lower screen: 0 none, 1 value store, 2 alarm clear,
    // 3 warning clear, 4 data restore, 5 init, 6 alarm reset, 7 test run
    input wire logic [2:0] CMD_IN,
    input wire logic CMD_VALID_IN,
    input wire fpmc_pkg::fpmc_data_t CMD_DATA_IN,
    // Driver status (pins)
    input wire logic TOOL_CONN_IN,
    input wire logic FREE_IN,
    input wire logic STOP_IN,
    input wire logic HALT_HOLD_IN,
    input wire logic LEGACY_MODE_IN,
    input wire logic [7:0] ALARM_CODE_IN,
    input wire logic [7:0] WARN_CODE_IN,
    input wire logic [4:0] IO_STATE_IN,
    // Panel outputs
    output logic [1:0] MODE_OUT,
    output logic [2:0] SCREEN_OUT,
    output logic TOP_SCREEN_OUT,
    output logic [3:0] GLYPH_OUT,
    output logic [7:0] CODE_OUT,
    output logic [4:0] DIGIT_LIT_OUT,
    output logic EDIT_LOCK_OUT,
    output logic CMD_REJECT_OUT,
    output logic ALARM_RESET_OUT,
    output logic ALARM_HIST_CLR_OUT,
    output logic WARN_HIST_CLR_OUT,
    output logic DATA_RESTORE_OUT,
    output logic INIT_OUT,
    output logic MOTOR_RUN_OUT,
    output fpmc_pkg::fpmc_data_t DATA_OUT
);
    // ==========================================================
    // Input synchronisers
    localparam int NS = 14;
    logic [NS-1:0] s1_q, s2_q;
    always_ff @(posedge REF_CLK_IN) begin
        s1_q <= {KEYS_IN, TOOL_CONN_IN, FREE_IN, STOP_IN, HALT_HOLD_IN, LEGACY_MODE_IN, IO_STATE_IN};
        s2_q <= s1_q;
    end
    fpmc_pkg::fpmc_keys_t keys;
    logic tool, free_i, stop_i, halt_hold, legacy;
    logic [4:0] io_s;
    assign {keys, tool, free_i, stop_i, halt_hold, legacy, io_s} = s2_q;

    // Key and tool edge detect on synchronised signals only
    fpmc_pkg::fpmc_keys_t keys_prev_q;
    logic tool_prev_q;
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            keys_prev_q <= '0;
            tool_prev_q <= 1'b0;
        end else begin
            keys_prev_q <= keys;
            tool_prev_q <= tool;
        end
    end
    logic mode_rel, set_press, tool_on, tool_off;
    // Mode acts on release so a long hold can be a lock toggle instead
    assign mode_rel = keys_prev_q.mode & ~keys.mode;
    assign set_press = keys.set & ~keys_prev_q.set;
    assign tool_on = tool & ~tool_prev_q;
    assign tool_off = ~tool & tool_prev_q;

    // ==========================================================
    // Navigation state
    logic [1:0] mode_q;
    logic top_q;
    logic [2:0] screen_q;
    logic lock_q;
    logic [31:0] hold_q;
    logic hold_fired_q;
    logic running_q;
    logic err_q;

    // Next monitor screen, skipping the lock-restricted warning history screen (4)
    function automatic logic [2:0] next_screen(input logic [2:0] s, input logic lk);
        logic [2:0] n;
        n = (s == 3'h5) ? 3'h0 : s + 3'h1;
        if (lk && n == 3'h4) begin
            n = 3'h5;
        end
        return n;
    endfunction

    // Long hold counter on top screen
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            hold_q <= '0;
            hold_fired_q <= 1'b0;
        end else if (!keys.mode || !top_q) begin
            hold_q <= '0;
            hold_fired_q <= keys.mode & hold_fired_q;
        end else if (hold_q == LOCK_HOLD - 1) begin
            hold_q <= '0;
            hold_fired_q <= 1'b1;
        end else if (!hold_fired_q) begin
            hold_q <= hold_q + 32'h0000_0001;
        end
    end
    logic lock_toggle;
    assign lock_toggle = keys.mode && top_q && !hold_fired_q && hold_q == LOCK_HOLD - 1;

    // Edit lock
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            lock_q <= 1'b0;
        end else if (lock_toggle) begin
            lock_q <= ~lock_q;
        end
    end

    // Mode and screen navigation
    logic leave_refused;
    assign leave_refused = mode_rel && !hold_fired_q && top_q && tool;
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            mode_q <= fpmc_pkg::MODE_MONITOR;
            top_q <= 1'b1;
            screen_q <= '0;
        end else if (tool_on) begin
            mode_q <= fpmc_pkg::MODE_MONITOR;
            top_q <= 1'b1;
            screen_q <= '0;
        end else if (mode_rel && !hold_fired_q) begin
            if (!top_q) begin
                top_q <= 1'b1;
            end else if (!tool) begin
                mode_q <= mode_q + 2'h1;
                screen_q <= '0;
            end
        end else if (set_press && top_q && !running_q && !(tool && mode_q != fpmc_pkg::MODE_MONITOR)) begin
            top_q <= tool ? 1'b1 : 1'b0;
        end else if (keys.up && !keys_prev_q.up && mode_q == fpmc_pkg::MODE_MONITOR) begin
            screen_q <= next_screen(screen_q, lock_q);
        end
    end

    // ==========================================================
    // Commands and data checks
    fpmc_pkg::fpmc_data_t data_q;
    logic rej_q, ar_q, ahc_q, whc_q, dr_q, ini_q;
    logic test_ok, acc_ok, dec_ok, data_ok;
    function automatic logic time_ok(input logic [15:0] t);
        return t <= fpmc_pkg::ACC_FINE_MAX ||
               (t >= fpmc_pkg::ACC_COARSE_MIN && t <= fpmc_pkg::ACC_COARSE_MAX &&
                (t % fpmc_pkg::ACC_COARSE_STEP) == 16'h0000);
    endfunction
    assign acc_ok = time_ok(CMD_DATA_IN.accel);
    assign dec_ok = time_ok(CMD_DATA_IN.decel);
    assign data_ok = CMD_DATA_IN.speed <= fpmc_pkg::SPEED_MAX &&
                     CMD_DATA_IN.torque <= fpmc_pkg::TORQUE_MAX && acc_ok && dec_ok;
    // Locked or tool-owned panel may not store, clear, restore or init; alarm reset is not blocked
    logic edit_block;
    assign edit_block = lock_q | tool;
    assign test_ok = !free_i && !stop_i && !(legacy && !halt_hold);

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            data_q <= '{fpmc_pkg::SPEED_RST, fpmc_pkg::TORQUE_RST, fpmc_pkg::ACC_RST, fpmc_pkg::ACC_RST};
            rej_q <= 1'b0;
            ar_q <= 1'b0;
            ahc_q <= 1'b0;
            whc_q <= 1'b0;
            dr_q <= 1'b0;
            ini_q <= 1'b0;
        end else begin
            rej_q <= 1'b0;
            ar_q <= 1'b0;
            ahc_q <= 1'b0;
            whc_q <= 1'b0;
            dr_q <= 1'b0;
            ini_q <= 1'b0;
            if (CMD_VALID_IN) begin
                case (CMD_IN)
                    3'h1: begin
                        if (edit_block || !data_ok || mode_q != fpmc_pkg::MODE_DATA) begin
                            rej_q <= 1'b1;
                        end else begin
                            data_q <= CMD_DATA_IN;
                        end
                    end
                    3'h2: begin
                        rej_q <= edit_block;
                        ahc_q <= !edit_block;
                    end
                    3'h3: begin
                        rej_q <= edit_block;
                        whc_q <= !edit_block;
                    end
                    3'h4: begin
                        rej_q <= edit_block;
                        dr_q <= !edit_block;
                        if (!edit_block) begin
                            data_q <= '{fpmc_pkg::SPEED_RST, fpmc_pkg::TORQUE_RST,
                                        fpmc_pkg::ACC_RST, fpmc_pkg::ACC_RST};
                        end
                    end
                    3'h5: begin
                        rej_q <= edit_block;
                        ini_q <= !edit_block;
                    end
                    3'h6: begin
                        ar_q <= 1'b1;
                    end
                    3'h7: begin
                        rej_q <= !test_ok || mode_q != fpmc_pkg::MODE_TEST || tool;
                    end
                    default: begin
                        rej_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Test run: only while up key held and conditions hold
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            running_q <= 1'b0;
        end else begin
            running_q <= mode_q == fpmc_pkg::MODE_TEST && !top_q && keys.up && test_ok && !tool;
        end
    end

    // Error glyph latch: set by forbidden set key or bad legacy run, cleared by any mode key
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            err_q <= 1'b0;
        end else if ((set_press && running_q) ||
                     (keys.up && mode_q == fpmc_pkg::MODE_TEST && !top_q && legacy && !halt_hold)) begin
            err_q <= 1'b1;
        end else if (mode_rel) begin
            err_q <= 1'b0;
        end
    end

    // ==========================================================
    // Blink sequencer: three on/off pairs of a notice glyph
    logic [31:0] blink_cnt_q;
    logic [2:0] phase_q;
    logic [3:0] notice_q;
    logic [31:0] note_hold_q;
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            phase_q <= '0;
            blink_cnt_q <= '0;
            notice_q <= fpmc_pkg::GL_BLANK;
        end else if (tool_on || tool_off) begin
            phase_q <= fpmc_pkg::BLINK_PHASES;
            blink_cnt_q <= '0;
            notice_q <= tool_on ? fpmc_pkg::GL_REMOTE_BUSY : fpmc_pkg::GL_LOCAL_AGAIN;
        end else if (phase_q != 3'h0) begin
            if (blink_cnt_q == BLINK_LEN - 1) begin
                blink_cnt_q <= '0;
                phase_q <= phase_q - 3'h1;
            end else begin
                blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
            end
        end
    end

    // Transient notice (lock glyphs, refused leave) shown for one blink period
    logic [3:0] flash_q;
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            flash_q <= fpmc_pkg::GL_BLANK;
            note_hold_q <= '0;
        end else if (lock_toggle) begin
            flash_q <= lock_q ? fpmc_pkg::GL_LOCK_OFF : fpmc_pkg::GL_LOCK_ON;
            note_hold_q <= BLINK_LEN;
        end else if (leave_refused) begin
            flash_q <= fpmc_pkg::GL_REMOTE_BUSY;
            note_hold_q <= BLINK_LEN;
        end else if (note_hold_q != 32'h0000_0000) begin
            note_hold_q <= note_hold_q - 32'h0000_0001;
        end
    end

    // ==========================================================
    // Output registers
    logic [3:0] glyph_d;
    always_comb begin
        glyph_d = fpmc_pkg::GL_VALUE;
        if (phase_q != 3'h0) begin
            glyph_d = phase_q[0] ? fpmc_pkg::GL_BLANK : notice_q;
        end else if (note_hold_q != 32'h0000_0000) begin
            glyph_d = flash_q;
        end else if (err_q) begin
            glyph_d = fpmc_pkg::GL_ERROR;
        end else if (mode_q == fpmc_pkg::MODE_MONITOR && screen_q == 3'h3) begin
            glyph_d = fpmc_pkg::GL_ALARM;
        end else if (mode_q == fpmc_pkg::MODE_MONITOR && screen_q == 3'h4) begin
            glyph_d = fpmc_pkg::GL_WARNING;
        end else if (mode_q == fpmc_pkg::MODE_MONITOR && screen_q == 3'h5) begin
            glyph_d = fpmc_pkg::GL_IO;
        end
    end
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            MODE_OUT <= fpmc_pkg::MODE_MONITOR;
            SCREEN_OUT <= '0;
            TOP_SCREEN_OUT <= 1'b1;
            GLYPH_OUT <= fpmc_pkg::GL_VALUE;
            CODE_OUT <= '0;
            DIGIT_LIT_OUT <= '0;
            EDIT_LOCK_OUT <= 1'b0;
            CMD_REJECT_OUT <= 1'b0;
            ALARM_RESET_OUT <= 1'b0;
            ALARM_HIST_CLR_OUT <= 1'b0;
            WARN_HIST_CLR_OUT <= 1'b0;
            DATA_RESTORE_OUT <= 1'b0;
            INIT_OUT <= 1'b0;
            MOTOR_RUN_OUT <= 1'b0;
            DATA_OUT <= '0;
        end else begin
            MODE_OUT <= mode_q;
            SCREEN_OUT <= screen_q;
            TOP_SCREEN_OUT <= top_q;
            GLYPH_OUT <= glyph_d;
            CODE_OUT <= (screen_q == 3'h4) ? WARN_CODE_IN : ALARM_CODE_IN;
            DIGIT_LIT_OUT <= (screen_q == 3'h5) ? io_s : 5'h00;
            EDIT_LOCK_OUT <= lock_q;
            CMD_REJECT_OUT <= rej_q;
            ALARM_RESET_OUT <= ar_q;
            ALARM_HIST_CLR_OUT <= ahc_q;
            WARN_HIST_CLR_OUT <= whc_q;
            DATA_RESTORE_OUT <= dr_q;
            INIT_OUT <= ini_q;
            MOTOR_RUN_OUT <= running_q;
            DATA_OUT <= data_q;
        end
    end

    // ==========================================================
    // Assertions
    sequence s_tool_edge;
        tool_on || tool_off;
    endsequence
    chk_mode_advance: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        mode_rel && !hold_fired_q && top_q && !tool && !tool_on |=> mode_q == $past(mode_q) + 2'h1)
        else $error("mode did not advance");
    chk_reset_monitor: assert property (@(posedge REF_CLK_IN)
        RST_IN |=> mode_q == fpmc_pkg::MODE_MONITOR && !lock_q)
        else $error("not monitor after reset");
    chk_lock_toggle: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        lock_toggle |=> lock_q != $past(lock_q))
        else $error("lock did not toggle");
    chk_store_locked: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        CMD_VALID_IN && CMD_IN == 3'h1 && lock_q |=> rej_q && data_q == $past(data_q))
        else $error("locked store accepted");
    chk_alarm_clr_lock: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        CMD_VALID_IN && CMD_IN == 3'h2 && lock_q |=> !ahc_q ##1 !ALARM_HIST_CLR_OUT)
        else $error("locked alarm clear done");
    chk_warn_clr_lock: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        CMD_VALID_IN && CMD_IN == 3'h3 && lock_q |=> !whc_q)
        else $error("locked warning clear done");
    chk_restore_lock: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        CMD_VALID_IN && CMD_IN == 3'h4 && lock_q |=> !dr_q)
        else $error("locked restore done");
    chk_init_lock: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        CMD_VALID_IN && CMD_IN == 3'h5 && lock_q |=> !ini_q)
        else $error("locked init done");
    chk_tool_blink: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        s_tool_edge |=> phase_q == fpmc_pkg::BLINK_PHASES)
        else $error("blink not started");
    chk_tool_stay: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        tool && !tool_on && mode_q == fpmc_pkg::MODE_MONITOR |=> mode_q == fpmc_pkg::MODE_MONITOR)
        else $error("left monitor with tool");
    chk_test_gate: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (free_i || stop_i) |=> !running_q)
        else $error("test ran with free or stop");
    chk_run_key: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        running_q |-> $past(keys.up))
        else $error("run without key");
endmodule
`default_nettype wire

/* File: fpmc_operator.sv */
// Operator model: works the panel keys for the bench.
// Assumes the bench clock; keys change just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module fpmc_operator (
    // Clock
    input wire logic clk_in,
    // Panel keys
    output var fpmc_pkg::fpmc_keys_t keys_out
);
    // ==========================================================
    // Key actions
    initial begin
        keys_out = '0;
    end
    // Hold the mode key for n cycles, then let the panel settle
    task automatic press_mode(input int n);
        @(posedge clk_in);
        keys_out.mode <= 1'b1;
        repeat (n) @(posedge clk_in);
        keys_out.mode <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
    // Hold any set of keys for n cycles, then let the panel settle
    task automatic press_keys(input fpmc_pkg::fpmc_keys_t k, input int n);
        @(posedge clk_in);
        keys_out <= k;
        repeat (n) @(posedge clk_in);
        keys_out <= '0;
        repeat (4) @(posedge clk_in);
    endtask
    // Jog: hold up for n cycles, then tap set while up is still held if asked
    task automatic hold_up(input int n, input logic tap_set);
        @(posedge clk_in);
        keys_out.up <= 1'b1;
        repeat (n) @(posedge clk_in);
        keys_out.set <= tap_set;
        repeat (2) @(posedge clk_in);
        keys_out <= '0;
        repeat (4) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the front panel mode controller.
// Assumes short lock and blink counts set at the instance.
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct packed {
        logic lock;
        logic [2:0] cmd;
        logic [15:0] speed;
        logic [5:0] pulses;
    } fpmc_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] cmd_in = 3'h0;
    logic cmd_valid = 1'b0;
    fpmc_pkg::fpmc_data_t cmd_data = {16'h0000, 8'hfa, 16'h0064, 16'h0064};
    logic tool = 1'b0;
    logic free_in = 1'b0;
    logic stop_in = 1'b0;
    logic halt_hold = 1'b1;
    logic legacy = 1'b0;
    logic [7:0] alarm_code = 8'h2a;
    logic [7:0] warn_code = 8'h51;
    logic [4:0] io_state = 5'h15;
    fpmc_pkg::fpmc_keys_t keys;
    fpmc_pkg::fpmc_data_t data_out;
    logic [1:0] mode_out;
    logic [3:0] glyph;
    logic top, lock, rej, arst, aclr, wclr, rest, init;
    logic [2:0] screen;
    logic [7:0] code;
    logic [4:0] digit;
    logic run;
    // Monitor screen after each up press: six unlocked, then five locked with the warning screen skipped
    logic [2:0] scr_exp [11] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h0};
    wire [5:0] pulses = {rej, arst, aclr, wclr, rest, init};
    int num_errors = 0;
    int n_compared = 0;
    int i, n, r;
    // Lock rows flip the edit lock; boundary speed rows probe the range check
    fpmc_row_t rows [13] = '{
        {1'b0, 3'h1, 16'h0fa0, 6'h00}, {1'b0, 3'h1, 16'h0fa1, 6'h20}, {1'b0, 3'h2, 16'h0000, 6'h08},
        {1'b0, 3'h3, 16'h0000, 6'h04}, {1'b0, 3'h4, 16'h0000, 6'h02}, {1'b0, 3'h5, 16'h0000, 6'h01},
        {1'b0, 3'h6, 16'h0000, 6'h10}, {1'b1, 3'h1, 16'h0010, 6'h20}, {1'b1, 3'h2, 16'h0000, 6'h20},
        {1'b1, 3'h3, 16'h0000, 6'h20}, {1'b1, 3'h4, 16'h0000, 6'h20}, {1'b1, 3'h5, 16'h0000, 6'h20},
        {1'b1, 3'h6, 16'h0000, 6'h10}};
    // ==========================================================
    // Clock, partner and design
    always #2.5 clk = ~clk;
    fpmc_operator op (.clk_in(clk), .keys_out(keys));
    fpmc_top #(.LOCK_HOLD(20), .BLINK_LEN(4)) dut (
        .REF_CLK_IN(clk), .RST_IN(rst), .KEYS_IN(keys), .CMD_IN(cmd_in), .CMD_VALID_IN(cmd_valid),
        .CMD_DATA_IN(cmd_data), .TOOL_CONN_IN(tool), .FREE_IN(free_in), .STOP_IN(stop_in),
        .HALT_HOLD_IN(halt_hold), .LEGACY_MODE_IN(legacy), .ALARM_CODE_IN(alarm_code), .WARN_CODE_IN(warn_code),
        .IO_STATE_IN(io_state), .MODE_OUT(mode_out), .SCREEN_OUT(screen), .TOP_SCREEN_OUT(top), .GLYPH_OUT(glyph),
        .CODE_OUT(code), .DIGIT_LIT_OUT(digit), .EDIT_LOCK_OUT(lock), .CMD_REJECT_OUT(rej), .ALARM_RESET_OUT(arst),
        .ALARM_HIST_CLR_OUT(aclr), .WARN_HIST_CLR_OUT(wclr), .DATA_RESTORE_OUT(rest), .INIT_OUT(init),
        .MOTOR_RUN_OUT(run), .DATA_OUT(data_out));
    // ==========================================================
    // Shared tasks
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Bounded wait for a mode and lock state; a miss ends the run
    task automatic settle(input logic [1:0] m, input logic l);
        #1;
        for (i = 0; i < 40 && !(mode_out === m && lock === l); i++) begin
            @(posedge clk);
            #1;
        end
        check("mode_lock_wait", {mode_out, lock}, {m, l});
        if (mode_out !== m || lock !== l) begin
            end_of_test();
        end
    endtask
    // Command taken at the next edge; pulses stand at the outputs one edge later
    task automatic send_cmd(input logic [2:0] c, input logic [15:0] s);
        @(posedge clk);
        cmd_in <= c;
        cmd_data.speed <= s;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    // Count how often the glyph starts to show within a fixed window
    task automatic count_blinks(input logic [3:0] g);
        logic prev;
        prev = 1'b0;
        n = 0;
        repeat (60) begin
            @(posedge clk);
            #1;
            if (glyph === g && !prev) n++;
            prev = (glyph === g);
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        #1;
        check("rst_outputs", {mode_out, top, lock}, 4'h2);
        @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("data_defaults", data_out, {16'h0000, 8'hfa, 16'h0064, 16'h0064});
        for (r = 1; r <= 5; r++) begin
            op.press_mode(2);
            settle(2'(r % 4), 1'b0);
        end
        for (r = 0; r < 13; r++) begin
            if (rows[r].lock !== lock) begin
                op.press_mode(30);
                settle(2'h1, rows[r].lock);
            end
            send_cmd(rows[r].cmd, rows[r].speed);
            check("cmd_pulses", pulses, rows[r].pulses);
            if (rows[r].cmd == 3'h1 && rows[r].pulses == 6'h00) begin
                check("data_store", data_out.speed, rows[r].speed);
            end
        end
        op.press_mode(30);
        settle(2'h1, 1'b0);
        op.press_mode(2);
        op.press_mode(2);
        settle(2'h3, 1'b0);
        // Test gating: free, then stop, then both off so the check is accepted
        for (r = 0; r < 3; r++) begin
            @(posedge clk);
            free_in <= (r == 0);
            stop_in <= (r == 1);
            repeat (4) @(posedge clk);
            send_cmd(3'h7, 16'h0000);
            check("test_gate", pulses, (r == 2) ? 6'h00 : 6'h20);
        end
        // Jog on the lower test screen: runs while held, set refused while running
        op.press_keys(fpmc_pkg::fpmc_keys_t'(4'h4), 2);
        #1;
        check("test_lower", top, 1'b0);
        fork
            op.hold_up(8, 1'b1);
            begin
                repeat (6) @(posedge clk);
                #1;
                check("run_held", run, 1'b1);
            end
        join
        #1;
        check("run_released", run, 1'b0);
        check("set_err_glyph", glyph, fpmc_pkg::GL_ERROR);
        check("set_err_top", top, 1'b0);
        op.press_mode(2);
        settle(2'h3, 1'b0);
        check("back_top", {top, glyph}, {1'b1, fpmc_pkg::GL_VALUE});
        // Legacy mode with the halt hold input off: no run, error glyph
        op.press_keys(fpmc_pkg::fpmc_keys_t'(4'h4), 2);
        @(posedge clk);
        legacy <= 1'b1;
        halt_hold <= 1'b0;
        fork
            op.hold_up(8, 1'b0);
            begin
                repeat (6) @(posedge clk);
                #1;
                check("legacy_run", run, 1'b0);
            end
        join
        #1;
        check("legacy_err", glyph, fpmc_pkg::GL_ERROR);
        @(posedge clk);
        legacy <= 1'b0;
        halt_hold <= 1'b1;
        op.press_mode(2);
        op.press_mode(2);
        settle(2'h0, 1'b0);
        // Monitor screens: codes and I/O digits, then the locked skip of the warning screen
        for (r = 0; r < 11; r++) begin
            if (r == 6) begin
                op.press_mode(30);
                settle(2'h0, 1'b1);
            end
            op.press_keys(fpmc_pkg::fpmc_keys_t'(4'h2), 2);
            #1;
            check("screen", screen, scr_exp[r]);
            check("io_digits", digit, (scr_exp[r] == 3'h5) ? io_state : 5'h00);
            if (scr_exp[r] == 3'h3) begin
                check("alarm_code", code, alarm_code);
            end
            if (scr_exp[r] == 3'h4) begin
                check("warn_code", code, warn_code);
            end
        end
        op.press_mode(30);
        settle(2'h0, 1'b0);
        @(posedge clk);
        tool <= 1'b1;
        count_blinks(fpmc_pkg::GL_REMOTE_BUSY);
        check("busy_blinks", n, 3);
        op.press_mode(2);
        #1;
        check("busy_glyph", glyph, fpmc_pkg::GL_REMOTE_BUSY);
        repeat (6) @(posedge clk);
        #1;
        check("tool_mode", mode_out, 2'h0);
        send_cmd(3'h2, 16'h0000);
        check("tool_cmd", pulses, 6'h20);
        @(posedge clk);
        tool <= 1'b0;
        count_blinks(fpmc_pkg::GL_LOCAL_AGAIN);
        check("local_blinks", n, 3);
        send_cmd(3'h2, 16'h0000);
        check("local_cmd", pulses, 6'h08);
        // Reset in mid-run from data mode
        op.press_mode(2);
        settle(2'h1, 1'b0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check("mid_rst", {mode_out, top, lock}, 4'h2);
        @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("mid_rst_run", {mode_out, screen, run}, 6'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
